// ===== rtl/iem_pkg.sv
// package: register map, field layout and shared types of the interrupt enable/mask block
package iem_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam logic [7:0]  OFF_IRQ_CTRL     = 8'h05;
    localparam logic [7:0]  OFF_MODULE_MASK  = 8'h06;
    localparam logic [7:0]  OFF_PENDING_ID   = 8'h0b;
    localparam logic [7:0]  OFF_EVT_STATUS   = 8'h10;
    localparam logic [7:0]  OFF_EVT_MASK     = 8'h11;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int          BIT_GLOBAL_EN    = 0;
    localparam int          BIT_IN_SERVICE   = 1;
    localparam int          BIT_SYS_GROUP    = 7;
    localparam int          BIT_GROUP_GAP    = 6;
    localparam logic [7:0]  RST_IRQ_CTRL     = 8'h00;
    localparam logic [7:0]  RST_MODULE_MASK  = 8'h00;
    localparam logic [7:0]  RST_PENDING_ID   = 8'h00;
    localparam logic [3:0]  RST_EVT          = 4'h0;

    // ****************************************************************
    // groups: six register modules plus the system group
    // ****************************************************************
    localparam int          NUM_MODULES      = 6;
    localparam int          NUM_GROUPS       = NUM_MODULES + 1;
    localparam int          SRCS_PER_GROUP   = 4;

    typedef struct packed {
        logic                   sys;
        logic [NUM_MODULES-1:0] modules;
    } iem_group_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } iem_reg_req_t;

    typedef struct packed {
        logic ack;
        logic ret;
        logic pop_ret;
    } iem_core_evt_t;

    typedef struct packed {
        logic sw_clear;
        logic blocked;
        logic returned;
        logic acked;
    } iem_evt_t;

    // group set laid out in register order, gap bit reads zero
    function automatic logic [7:0] iem_to_reg(input iem_group_t g);
        iem_to_reg = {g.sys, 1'b0, g.modules};
    endfunction : iem_to_reg

    function automatic iem_group_t iem_from_reg(input logic [7:0] r);
        iem_from_reg = '{sys: r[BIT_SYS_GROUP], modules: r[NUM_MODULES-1:0]};
    endfunction : iem_from_reg

endpackage : iem_pkg

// ===== rtl/iem_pending.sv
// pending identifier: per-group flag of enabled sources awaiting service
`timescale 1ns/1ps
module iem_pending #(
    parameter int SRCS = iem_pkg::SRCS_PER_GROUP
) (
    input  wire logic                                     clk,
    input  wire logic                                     rst_n,
    input  wire logic [iem_pkg::NUM_GROUPS-1:0][SRCS-1:0] src_flag,
    input  wire logic [iem_pkg::NUM_GROUPS-1:0][SRCS-1:0] src_en,
    output iem_pkg::iem_group_t                           pending
);
    import iem_pkg::*;

    logic [NUM_GROUPS-1:0] next_pending;

    always_comb begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            next_pending[g] = |(src_flag[g] & src_en[g]);
        end
    end

    // drops on the clock edge after the sources are disabled or their flags cleared
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending <= iem_from_reg(RST_PENDING_ID);
        end else begin
            pending <= iem_group_t'(next_pending);
        end
    end

    // the edge right after reset compares against a cleared flop, so it is skipped
    AST_PEND_TRACKS: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> pending == iem_group_t'($past(next_pending)))
        else $error("pending identifier does not follow enabled flags");

endmodule : iem_pending

// ===== rtl/iem_ctrl.sv
// interrupt enable, in-service and module mask control for the core
`timescale 1ns/1ps
module iem_ctrl
    import iem_pkg::*;
#(
    parameter int SRCS = SRCS_PER_GROUP
) (
    input  wire logic                                     CLK,
    input  wire logic                                     RST_N,
    input  iem_pkg::iem_reg_req_t                         REG_REQ,
    output logic [iem_pkg::DATA_W-1:0]                    REG_RDATA,
    input  iem_pkg::iem_core_evt_t                        CORE_EVT,
    input  wire logic [iem_pkg::NUM_GROUPS-1:0][SRCS-1:0] SRC_FLAG,
    input  wire logic [iem_pkg::NUM_GROUPS-1:0][SRCS-1:0] SRC_EN,
    output logic                                          IRQ_REQ,
    output iem_pkg::iem_group_t                           PENDING_ID,
    output logic                                          IRQ_OUT
);
    import iem_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    logic       global_irq_enable;
    logic       in_service_flag;
    iem_group_t module_mask_reg;
    iem_group_t pending_identifier_reg;
    iem_evt_t   evt_status;
    iem_evt_t   evt_mask;
    iem_evt_t   evt_now;
    logic [DATA_W-1:0] next_rdata;
    logic       wr_ctrl;
    logic       wr_mask;
    logic       wr_evt_status;
    logic       wr_evt_mask;
    logic       masked_pending;
    logic       exit_op;

    // ****************************************************************
    // pending identifier
    // ****************************************************************
    iem_pending #(
        .SRCS     (SRCS)
    ) u_pending (
        .clk      (CLK),
        .rst_n    (RST_N),
        .src_flag (SRC_FLAG),
        .src_en   (SRC_EN),
        .pending  (pending_identifier_reg)
    );

    assign PENDING_ID = pending_identifier_reg;

    // ****************************************************************
    // write decode
    // ****************************************************************
    assign wr_ctrl       = REG_REQ.wr && (REG_REQ.addr == OFF_IRQ_CTRL);
    assign wr_mask       = REG_REQ.wr && (REG_REQ.addr == OFF_MODULE_MASK);
    assign wr_evt_status = REG_REQ.wr && (REG_REQ.addr == OFF_EVT_STATUS);
    assign wr_evt_mask   = REG_REQ.wr && (REG_REQ.addr == OFF_EVT_MASK);
    assign exit_op       = CORE_EVT.ret || CORE_EVT.pop_ret;

    // ****************************************************************
    // global enable
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            global_irq_enable <= RST_IRQ_CTRL[BIT_GLOBAL_EN];
        end else if (wr_ctrl) begin
            global_irq_enable <= REG_REQ.wdata[BIT_GLOBAL_EN];
        end
    end

    // ****************************************************************
    // in-service flag
    // ****************************************************************
    // an acknowledge in the same cycle as a clear must win, otherwise the
    // routine just entered would run with delivery reopened under it
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            in_service_flag <= RST_IRQ_CTRL[BIT_IN_SERVICE];
        end else if (CORE_EVT.ack) begin
            in_service_flag <= 1'b1;
        end else if (wr_ctrl) begin
            in_service_flag <= REG_REQ.wdata[BIT_IN_SERVICE];
        end else if (exit_op) begin
            in_service_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // module mask
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            module_mask_reg <= iem_from_reg(RST_MODULE_MASK);
        end else if (wr_mask) begin
            module_mask_reg <= iem_from_reg(REG_REQ.wdata);
        end
    end

    // ****************************************************************
    // request to the core
    // ****************************************************************
    // kept combinational so a cleared enable or a set in-service flag cuts the
    // request in the same cycle the flop changes, the cycle after the write or the ack
    assign masked_pending = |(module_mask_reg & pending_identifier_reg);
    assign IRQ_REQ = global_irq_enable && !in_service_flag && masked_pending;

    // ****************************************************************
    // event status and interrupt output
    // ****************************************************************
    always_comb begin
        evt_now          = '0;
        evt_now.acked    = CORE_EVT.ack;
        evt_now.returned = exit_op && in_service_flag;
        evt_now.blocked  = global_irq_enable && in_service_flag && masked_pending;
        evt_now.sw_clear = wr_ctrl && in_service_flag && !REG_REQ.wdata[BIT_IN_SERVICE];
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            evt_status <= iem_evt_t'(RST_EVT);
        end else if (wr_evt_status) begin
            evt_status <= (evt_status & ~iem_evt_t'(REG_REQ.wdata[3:0])) | evt_now;
        end else begin
            evt_status <= evt_status | evt_now;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            evt_mask <= iem_evt_t'(RST_EVT);
        end else if (wr_evt_mask) begin
            evt_mask <= iem_evt_t'(REG_REQ.wdata[3:0]);
        end
    end

    assign IRQ_OUT = |(evt_status & evt_mask);

    // ****************************************************************
    // read path
    // ****************************************************************
    always_comb begin
        next_rdata = '0;
        case (REG_REQ.addr)
            OFF_IRQ_CTRL:    next_rdata = {6'h00, in_service_flag, global_irq_enable};
            OFF_MODULE_MASK: next_rdata = iem_to_reg(module_mask_reg);
            OFF_PENDING_ID:  next_rdata = iem_to_reg(pending_identifier_reg);
            OFF_EVT_STATUS:  next_rdata = {4'h0, evt_status};
            OFF_EVT_MASK:    next_rdata = {4'h0, evt_mask};
            default:         next_rdata = '0;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            REG_RDATA <= '0;
        end else if (REG_REQ.rd) begin
            REG_RDATA <= next_rdata;
        end else begin
            REG_RDATA <= '0;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_RESET_CLEARS: assert property (@(posedge CLK)
        !RST_N |=> (!global_irq_enable && !in_service_flag && module_mask_reg == '0))
        else $error("reset left control or mask state nonzero");

    AST_CTRL_RESERVED: assert property (@(posedge CLK) disable iff (!RST_N)
        REG_REQ.rd && REG_REQ.addr == OFF_IRQ_CTRL |=> REG_RDATA[7:2] == 6'h00)
        else $error("control reserved bits read nonzero");

    AST_ACK_SETS_INS: assert property (@(posedge CLK) disable iff (!RST_N)
        CORE_EVT.ack |=> in_service_flag && !IRQ_REQ)
        else $error("acknowledge did not set in-service");

    AST_NO_REQ_IN_SERVICE: assert property (@(posedge CLK) disable iff (!RST_N)
        in_service_flag |-> !IRQ_REQ)
        else $error("request raised while in service");

    AST_SW_CLEAR_REOPENS: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_ctrl && !CORE_EVT.ack && !REG_REQ.wdata[BIT_IN_SERVICE] && REG_REQ.wdata[BIT_GLOBAL_EN]
        ##1 (masked_pending && !CORE_EVT.ack) |-> IRQ_REQ)
        else $error("software clear did not reopen delivery");

    AST_RETURN_CLEARS: assert property (@(posedge CLK) disable iff (!RST_N)
        exit_op && !CORE_EVT.ack && !wr_ctrl |=> !in_service_flag)
        else $error("return did not clear in-service");

    AST_GLOBAL_GATES: assert property (@(posedge CLK) disable iff (!RST_N)
        !global_irq_enable |-> !IRQ_REQ)
        else $error("request raised with global enable low");

    AST_MASK_BLOCKS: assert property (@(posedge CLK) disable iff (!RST_N)
        (module_mask_reg & pending_identifier_reg) == '0 |-> !IRQ_REQ)
        else $error("request raised by a masked group");

    AST_MASK_ALLOWS: assert property (@(posedge CLK) disable iff (!RST_N)
        global_irq_enable && !in_service_flag && module_mask_reg.sys
        && pending_identifier_reg.sys |-> IRQ_REQ)
        else $error("unmasked system group did not request");

    AST_MASK_LAYOUT: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_mask ##1 REG_REQ.rd && REG_REQ.addr == OFF_MODULE_MASK && !wr_mask
        |=> REG_RDATA == ($past(REG_REQ.wdata, 2) & 8'hbf))
        else $error("mask register readback wrong");

    AST_REQ_EQUATION: assert property (@(posedge CLK) disable iff (!RST_N)
        IRQ_REQ == (global_irq_enable && !in_service_flag
                    && (iem_to_reg(module_mask_reg) & iem_to_reg(pending_identifier_reg)) != 8'h00))
        else $error("request does not match enable and mask");

    AST_ENABLE_WRITE: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_ctrl |=> global_irq_enable == $past(REG_REQ.wdata[BIT_GLOBAL_EN]))
        else $error("global enable does not follow control write");

    AST_SW_WRITE_INS: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_ctrl && !CORE_EVT.ack |=> in_service_flag == $past(REG_REQ.wdata[BIT_IN_SERVICE]))
        else $error("in-service does not follow control write");

    AST_MASK_GAP_ZERO: assert property (@(posedge CLK) disable iff (!RST_N)
        REG_REQ.rd && REG_REQ.addr == OFF_MODULE_MASK |=> !REG_RDATA[BIT_GROUP_GAP])
        else $error("mask gap bit read nonzero");

    AST_PEND_READ: assert property (@(posedge CLK) disable iff (!RST_N)
        REG_REQ.rd && REG_REQ.addr == OFF_PENDING_ID
        |=> REG_RDATA == {$past(pending_identifier_reg.sys), 1'b0,
                          $past(pending_identifier_reg.modules)})
        else $error("pending identifier readback wrong");

    // ****************************************************************
    // event and bus checks
    // ****************************************************************
    AST_RDATA_IDLE: assert property (@(posedge CLK) disable iff (!RST_N)
        !REG_REQ.rd |=> REG_RDATA == 8'h00)
        else $error("read data not zero outside the read cycle");

    AST_ACK_EVENT: assert property (@(posedge CLK) disable iff (!RST_N)
        CORE_EVT.ack |=> evt_status.acked)
        else $error("acknowledge event not recorded");

    AST_EVT_W1C: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_evt_status && REG_REQ.wdata[0] && !CORE_EVT.ack |=> !evt_status.acked)
        else $error("write one did not clear acknowledge event");

endmodule : iem_ctrl

// ===== tb/iem_core_model.sv
// core model: takes a request after a delay and runs returns when told to
`timescale 1ns/1ps
module iem_core_model
    import iem_pkg::*;
#(
    parameter int ACK_DELAY = 3
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               irq_req,
    input  wire logic               auto_ack,
    output iem_pkg::iem_core_evt_t  core_evt
);
    int wait_cnt = 0;

    initial core_evt = '0;

    // a slow core: the request must stay up for ACK_DELAY+1 cycles before it is taken
    always @(posedge clk) begin
        if (!rst_n || !auto_ack || !irq_req || core_evt.ack) begin
            wait_cnt     <= 0;
            core_evt.ack <= 1'b0;
        end else if (wait_cnt == ACK_DELAY) begin
            core_evt.ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end

    task automatic finish_isr(input logic pop);
        @(posedge clk);
        core_evt.ret     <= !pop;
        core_evt.pop_ret <= pop;
        @(posedge clk);
        core_evt.ret     <= 1'b0;
        core_evt.pop_ret <= 1'b0;
    endtask : finish_isr
endmodule : iem_core_model

// ===== tb/tb_top.sv
// testbench of the interrupt enable/mask block
`timescale 1ns/1ps
module tb_top;
    import iem_pkg::*;
    logic                                    clk;
    logic                                    rst_n;
    iem_reg_req_t                            req;
    logic [DATA_W-1:0]                       rdata;
    iem_core_evt_t                           evt;
    logic [NUM_GROUPS-1:0][SRCS_PER_GROUP-1:0] src_flag;
    logic [NUM_GROUPS-1:0][SRCS_PER_GROUP-1:0] src_en;
    logic                                    irq_req;
    iem_group_t                              pend;
    logic                                    irq_out;
    logic                                    auto_ack;
    logic [7:0]                              mb;
    int                                      err_count = 0;
    int                                      check_count = 0;

    iem_ctrl i_iem_ctrl (.CLK(clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
        .CORE_EVT(evt), .SRC_FLAG(src_flag), .SRC_EN(src_en), .IRQ_REQ(irq_req),
        .PENDING_ID(pend), .IRQ_OUT(irq_out));
    iem_core_model i_iem_core_model (.clk(clk), .rst_n(rst_n), .irq_req(irq_req),
        .auto_ack(auto_ack), .core_evt(evt));

    // ****************************************************************
    // bus access and comparison
    // ****************************************************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // every task but chk returns on a rising edge, so what follows is driven at an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk("read data", exp, rdata);
        @(posedge clk);
    endtask : rdc

    // write then read back with no gap between the strobes
    task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk("read data", exp, rdata);
        @(posedge clk);
    endtask : wrc

    task automatic irq(input logic exp);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_req", {7'h00, exp}, {7'h00, irq_req});
        @(posedge clk);
    endtask : irq

    task automatic pnd(input logic [7:0] exp);
        #1;
        chk("pending_id", exp, {pend.sys, 1'b0, pend.modules});
        @(posedge clk);
    endtask : pnd

    task automatic results();
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        results();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        rst_n    = 1'b0;
        req      = '0;
        src_flag = '0;
        src_en   = '0;
        auto_ack = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rdc(OFF_IRQ_CTRL, 8'h00);
        rdc(OFF_MODULE_MASK, 8'h00);
        wrc(OFF_IRQ_CTRL, 8'hff, 8'h03);
        wrc(OFF_MODULE_MASK, 8'hff, 8'hbf);
        wr(OFF_IRQ_CTRL, 8'h01);
        rdc(8'h20, 8'h00);
        // every group in turn, the system group last
        for (int g = 0; g < NUM_GROUPS; g++) begin
            mb = (g == NUM_MODULES) ? 8'h80 : (8'h01 << g);
            src_flag[g][g % SRCS_PER_GROUP] <= 1'b1;
            src_en[g][g % SRCS_PER_GROUP]   <= 1'b1;
            wr(OFF_MODULE_MASK, mb);
            irq(1'b1);
            pnd(mb);
            rdc(OFF_PENDING_ID, mb);
            wr(OFF_MODULE_MASK, ~mb);
            irq(1'b0);
            src_en[g] <= '0;
            irq(1'b0);
            rdc(OFF_PENDING_ID, 8'h00);
            src_flag[g] <= '0;
        end
        src_flag[2][1] <= 1'b1;
        src_en[2][1]   <= 1'b1;
        wr(OFF_MODULE_MASK, 8'h04);
        wr(OFF_IRQ_CTRL, 8'h00);
        irq(1'b0);
        wr(OFF_IRQ_CTRL, 8'h01);
        irq(1'b1);
        // the model takes the request; the source keeps pending meanwhile
        auto_ack <= 1'b1;
        repeat (10) @(posedge clk);
        auto_ack <= 1'b0;
        rdc(OFF_IRQ_CTRL, 8'h03);
        irq(1'b0);
        i_iem_core_model.finish_isr(1'b0);
        irq(1'b1);
        rdc(OFF_IRQ_CTRL, 8'h01);
        wr(OFF_IRQ_CTRL, 8'h03);
        i_iem_core_model.finish_isr(1'b1);
        rdc(OFF_IRQ_CTRL, 8'h01);
        wr(OFF_IRQ_CTRL, 8'h03);
        irq(1'b0);
        wr(OFF_IRQ_CTRL, 8'h01);
        irq(1'b1);
        // sticky acknowledge event behind its mask
        wr(OFF_EVT_MASK, 8'h01);
        #1;
        chk("irq_out", 8'h01, {7'h00, irq_out});
        wr(OFF_EVT_MASK, 8'h00);
        #1;
        chk("irq_out", 8'h00, {7'h00, irq_out});
        wr(OFF_EVT_MASK, 8'h01);
        wr(OFF_EVT_STATUS, 8'h01);
        #1;
        chk("irq_out", 8'h00, {7'h00, irq_out});
        // returned, blocked and software-clear events stay sticky
        rdc(OFF_EVT_STATUS, 8'h0e);
        // reset in mid-run with both registers loaded
        wr(OFF_MODULE_MASK, 8'h81);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(OFF_IRQ_CTRL, 8'h00);
        rdc(OFF_MODULE_MASK, 8'h00);
        results();
    end
endmodule : tb_top
